// ### flash_host_cfg.svh
// timing and command constants for the sector program host
// assumes a 10 ns system clock and a byte-wide parallel flash outside
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ----------------------------------------
// clock and pin timing
// ----------------------------------------
`define CLK_NS        10
`define T_WP_NS       90
`define T_WPH_NS      100
`define T_ACC_NS      200
`define T_OEH_NS      150
`define T_BLC_US      150
`define T_WC_MS       10
`define SYNC_STAGES   2

// ----------------------------------------
// sector geometry
// ----------------------------------------
`define SECTOR_BYTES  128
`define ERASED_BYTE   8'h_FF

// ----------------------------------------
// protection command words {address, data}
// ----------------------------------------
`define CMD_ADDR_A    16'h_5555
`define CMD_ADDR_B    16'h_2AAA
`define CMD_DATA_1    8'h_AA
`define CMD_DATA_2    8'h_55
`define CMD_DATA_EN   8'h_A0
`define CMD_DATA_ERS  8'h_80
`define CMD_DATA_DIS  8'h_20
`define CMD_LAST_EN   3'h_2
`define CMD_LAST_DIS  3'h_5

`endif

// ### flash_host_pkg.sv
// types shared by the sector program host, its checker, the flash model and the bench
// assumes flash_host_cfg.svh for all numeric constants
package flash_host_pkg;

   typedef enum logic [1:0] {
      MODE_PROGRAM,
      MODE_PROT_ENABLE,
      MODE_PROT_DISABLE
   } prog_mode_e;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_CMD_SET,
      ST_LOAD,
      ST_LOAD_SET,
      ST_WR_LOW,
      ST_WR_HIGH,
      ST_WAIT_BLC,
      ST_RD_LOW,
      ST_RD_HIGH,
      ST_DONE
   } host_state_e;

   typedef struct packed {
      prog_mode_e mode;
      logic [8:0] sector;
   } start_req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  dout;
      logic        doe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
   } flash_pins_s;

endpackage

// ### sector_buf.sv
// sector staging memory, one write port and one registered read port
// assumes writer and reader share clk
`timescale 1ns/1ps
module sector_buf #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 8
) (
   // clock
   input  wire logic                     clk,
   // write side
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   // read side
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ### sector_program_protect.sv
// host controller that loads and programs one flash sector over its pins
// assumes a byte-wide flash with active-low strobes; data_lines_in is asynchronous
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

//Contract
// (RULE_01) every write-strobe fall during a load carries the same sector address bits
// (RULE_02) after protection unlock codes, all byte loads keep one fixed sector
// (RULE_03) output enable stays high while write strobe and chip select are low
// (RULE_04) unloaded bytes of a programmed sector become all ones
// (RULE_05) each byte load starts within the byte load window of the last
// (RULE_06) protection turns on only when the enable program cycle finishes
// (RULE_07) protection turns off only when the disable program period finishes
// (RULE_08) protection enable or disable commands are followed by exactly 128 bytes
// (RULE_09) device takes address on later falling strobe, data on earlier rise
// (RULE_10) during programming the last byte reads back with its poll bit inverted
// (RULE_11) during programming successive reads flip the toggle flag bit
// (RULE_12) identification codes match for hardware and software entry methods
// (RULE_13) a missed byte load window ends loading and starts the program cycle
module sector_program_protect
   import flash_host_pkg::*;
#(
   parameter int BLC_CYC  = (`T_BLC_US * 1000 + `CLK_NS - 1) / `CLK_NS,
   parameter int PROG_CYC = (`T_WC_MS * 1000000) / `CLK_NS
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // sector staging
   input  wire logic                     buf_wr,
   input  wire logic [6:0]               buf_addr,
   input  wire logic [7:0]               buf_data,
   // command
   input  wire logic                     start,
   input  flash_host_pkg::start_req_s    start_req,
   // status
   output logic                          busy,
   output logic                          done,
   output logic                          err,
   output logic                          prot_active,
   // flash pins
   output flash_host_pkg::flash_pins_s   pins,
   input  wire logic [7:0]               data_lines_in
);
   import flash_host_pkg::*;

   localparam int WP_CYC  = (`T_WP_NS + `CLK_NS - 1) / `CLK_NS;
   localparam int WPH_CYC = (`T_WPH_NS + `CLK_NS - 1) / `CLK_NS;
   localparam int RD_CYC  = (`T_ACC_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_STAGES;
   localparam int OEH_CYC = (`T_OEH_NS + `CLK_NS - 1) / `CLK_NS;

   typedef struct packed {
      host_state_e st;
      logic [19:0] cnt;
      logic [19:0] poll_cnt;
      logic [7:0]  idx;
      logic [`SECTOR_BYTES-1:0] mask;
      logic [2:0]  cmd_idx;
      logic        from_cmd;
      prog_mode_e  mode;
      logic [8:0]  sector;
      logic [6:0]  last_addr;
      logic [7:0]  last_data;
      logic        have_last;
      logic        prev_toggle;
      logic        have_prev;
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      flash_pins_s pins;
      logic        busy;
      logic        done;
      logic        err;
      logic        prot;
   } host_s;

   host_s      state_reg;
   host_s      state_next;
   logic [7:0] buf_rdata;
   logic [7:0] samp;
   logic [23:0] cmd_word;

   // ----------------------------------------
   // staging buffer
   // ----------------------------------------
   sector_buf #(
      .DEPTH (`SECTOR_BYTES),
      .WIDTH (8)
   ) u_buf (
      .clk     (clk),
      .wr_en   (buf_wr & ~state_reg.busy),
      .wr_addr (buf_addr),
      .wr_data (buf_data),
      .rd_addr (state_reg.idx[6:0]),
      .rd_data (buf_rdata)
   );

   // ----------------------------------------
   // protection command table
   // ----------------------------------------
   function automatic logic [23:0] cmd_lookup(input prog_mode_e m, input logic [2:0] i);
      logic [7:0] third;
      third = (m == MODE_PROT_ENABLE) ? `CMD_DATA_EN : `CMD_DATA_ERS;
      case (i)
         3'h_0:   cmd_lookup = {`CMD_ADDR_A, `CMD_DATA_1};
         3'h_1:   cmd_lookup = {`CMD_ADDR_B, `CMD_DATA_2};
         3'h_2:   cmd_lookup = {`CMD_ADDR_A, third};
         3'h_3:   cmd_lookup = {`CMD_ADDR_A, `CMD_DATA_1};
         3'h_4:   cmd_lookup = {`CMD_ADDR_B, `CMD_DATA_2};
         default: cmd_lookup = {`CMD_ADDR_A, `CMD_DATA_DIS};
      endcase
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_next       = state_reg;
      state_next.done  = 1'b0;
      state_next.sync1 = data_lines_in;
      state_next.sync2 = state_reg.sync1;
      samp             = state_reg.sync2;
      cmd_word         = cmd_lookup(state_reg.mode, state_reg.cmd_idx);
      if (buf_wr && !state_reg.busy) begin
         state_next.mask[buf_addr] = 1'b1;
      end
      case (state_reg.st)
         ST_IDLE: begin
            if (start) begin
               state_next.mode     = start_req.mode;
               state_next.sector   = start_req.sector;
               state_next.busy     = 1'b1;
               state_next.err      = 1'b0;
               state_next.idx      = 8'h_00;
               state_next.cmd_idx  = 3'h_0;
               state_next.st = (start_req.mode == MODE_PROGRAM) ? ST_LOAD : ST_CMD_SET;
            end
         end
         ST_CMD_SET: begin
            // oe held high while strobes are low
            // (RULE_03) output enable high
            state_next.pins = '{addr: cmd_word[23:8], dout: cmd_word[7:0], doe: 1'b1,
                                ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
            state_next.from_cmd = 1'b1;
            state_next.cnt      = 20'(WP_CYC - 1);
            state_next.st       = ST_WR_LOW;
         end
         ST_LOAD: begin
            if (state_reg.idx == 8'(`SECTOR_BYTES)) begin
               state_next.cnt = 20'(BLC_CYC - 1);
               state_next.st  = state_reg.have_last ? ST_WAIT_BLC : ST_DONE;
            // (RULE_08) full sector after commands
            end else if (state_reg.mode != MODE_PROGRAM || state_reg.mask[state_reg.idx[6:0]]) begin
               state_next.st = ST_LOAD_SET;
            end else begin
               state_next.idx = state_reg.idx + 8'h_01;
            end
         end
         ST_LOAD_SET: begin
            // (RULE_01) fixed sector address
            // (RULE_02) same sector after unlock
            state_next.pins.addr = {state_reg.sector, state_reg.idx[6:0]};
            state_next.pins.dout = state_reg.mask[state_reg.idx[6:0]] ? buf_rdata : `ERASED_BYTE;
            state_next.pins.doe  = 1'b1;
            state_next.pins.ce_n = 1'b0;
            state_next.pins.oe_n = 1'b1;
            state_next.pins.we_n = 1'b0;
            state_next.last_addr = state_reg.idx[6:0];
            state_next.last_data = state_next.pins.dout;
            state_next.have_last = 1'b1;
            state_next.from_cmd  = 1'b0;
            state_next.cnt       = 20'(WP_CYC - 1);
            state_next.st        = ST_WR_LOW;
         end
         ST_WR_LOW: begin
            if (state_reg.cnt == 20'h_0_0000) begin
               state_next.pins.we_n = 1'b1;
               state_next.cnt       = 20'(WPH_CYC - 1);
               state_next.st        = ST_WR_HIGH;
            end else begin
               state_next.cnt = state_reg.cnt - 20'h_0_0001;
            end
         end
         ST_WR_HIGH: begin
            if (state_reg.cnt == 20'h_0_0000) begin
               state_next.pins.ce_n = 1'b1;
               state_next.pins.doe  = 1'b0;
               if (!state_reg.from_cmd) begin
                  // (RULE_05) next load starts promptly
                  state_next.idx = state_reg.idx + 8'h_01;
                  state_next.st  = ST_LOAD;
               end else if (state_reg.cmd_idx == ((state_reg.mode == MODE_PROT_ENABLE) ?
                                                  `CMD_LAST_EN : `CMD_LAST_DIS)) begin
                  state_next.st = ST_LOAD;
               end else begin
                  state_next.cmd_idx = state_reg.cmd_idx + 3'h_1;
                  state_next.st      = ST_CMD_SET;
               end
            end else begin
               state_next.cnt = state_reg.cnt - 20'h_0_0001;
            end
         end
         ST_WAIT_BLC: begin
            // (RULE_13) let the load window lapse
            if (state_reg.cnt == 20'h_0_0000) begin
               state_next.pins.addr = {state_reg.sector, state_reg.last_addr};
               state_next.pins.ce_n = 1'b0;
               state_next.pins.oe_n = 1'b0;
               state_next.cnt       = 20'(RD_CYC - 1);
               state_next.poll_cnt  = 20'h_0_0000;
               state_next.have_prev = 1'b0;
               state_next.st        = ST_RD_LOW;
            end else begin
               state_next.cnt = state_reg.cnt - 20'h_0_0001;
            end
         end
         ST_RD_LOW, ST_RD_HIGH: begin
            state_next.poll_cnt = state_reg.poll_cnt + 20'h_0_0001;
            if (state_reg.cnt != 20'h_0_0000) begin
               state_next.cnt = state_reg.cnt - 20'h_0_0001;
            end else if (state_reg.st == ST_RD_LOW) begin
               state_next.pins.ce_n  = 1'b1;
               state_next.pins.oe_n  = 1'b1;
               state_next.prev_toggle = samp[6];
               state_next.have_prev  = 1'b1;
               state_next.cnt        = 20'(OEH_CYC - 1);
               state_next.st         = ST_RD_HIGH;
               // (RULE_10) poll bit matches
               // (RULE_11) toggle flag stopped
               if (state_reg.have_prev && samp[6] == state_reg.prev_toggle &&
                   samp[7] == state_reg.last_data[7]) begin
                  state_next.st = ST_DONE;
               end
            end else begin
               state_next.pins.ce_n = 1'b0;
               state_next.pins.oe_n = 1'b0;
               state_next.cnt       = 20'(RD_CYC - 1);
               state_next.st        = ST_RD_LOW;
            end
            if (state_reg.poll_cnt == 20'(PROG_CYC - 1)) begin
               state_next.pins.ce_n = 1'b1;
               state_next.pins.oe_n = 1'b1;
               state_next.err       = 1'b1;
               state_next.st        = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next.busy      = 1'b0;
            state_next.done      = 1'b1;
            state_next.mask      = '0;
            state_next.have_last = 1'b0;
            state_next.st        = ST_IDLE;
            // (RULE_06) protect set at cycle end
            // (RULE_07) protect cleared at cycle end
            if (!state_reg.err && state_reg.mode == MODE_PROT_ENABLE) begin
               state_next.prot = 1'b1;
            end else if (!state_reg.err && state_reg.mode == MODE_PROT_DISABLE) begin
               state_next.prot = 1'b0;
            end
         end
         default: begin
            state_next.st = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg      <= '0;
         state_reg.st   <= ST_IDLE;
         state_reg.pins <= '{addr: 16'h_0000, dout: 8'h_00, doe: 1'b0,
                             ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end else begin
         state_reg <= state_next;
      end
   end

   assign busy        = state_reg.busy;
   assign done        = state_reg.done;
   assign err         = state_reg.err;
   assign prot_active = state_reg.prot;
   assign pins        = state_reg.pins;
endmodule

// ### sector_program_protect_asserts.sv
// checker: pin protocol of the sector program host
// assumes binding into sector_program_protect, one clock domain
`timescale 1ns/1ps
module sector_program_protect_asserts
   import flash_host_pkg::*;
#(
   parameter int BLC_CYC  = 15000,
   parameter int PROG_CYC = 1000000
) (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   sys_rst,
   // command and status
   input wire logic                   start,
   input flash_host_pkg::start_req_s  start_req,
   input wire logic                   busy,
   input wire logic                   done,
   input wire logic                   err,
   input wire logic                   prot_active,
   // flash pins
   input flash_host_pkg::flash_pins_s pins
);
   import flash_host_pkg::*;
   prog_mode_e  mode_reg;
   logic [8:0]  sec_reg;
   logic [7:0]  nwr_reg;
   logic [15:0] gap_reg;
   logic [31:0] idle_reg;
   logic [7:0]  skip;
   assign skip = (mode_reg == MODE_PROT_ENABLE) ? 8'h_03 :
                 (mode_reg == MODE_PROT_DISABLE) ? 8'h_06 : 8'h_00;
   // ----------------------------------------
   // job tracking
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (start && !busy) begin
         mode_reg <= start_req.mode;
         sec_reg  <= start_req.sector;
      end
      if (sys_rst || (start && !busy)) begin
         nwr_reg <= 8'h_00;
      end else if ($fell(pins.we_n)) begin
         nwr_reg <= nwr_reg + 8'h_01;
      end
      gap_reg  <= $fell(pins.we_n) ? 16'h_0000 : gap_reg + {15'h_0000, gap_reg != 16'h_FFFF};
      idle_reg <= (!pins.we_n || sys_rst) ? 32'h_0000_0000 :
                  idle_reg + {31'h_0000_0000, idle_reg != 32'h_FFFF_FFFF};
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence we_held;
      (!pins.we_n && pins.doe && $stable(pins.addr) && $stable(pins.dout))[*8];
   endsequence
   sequence data_load;
      $fell(pins.we_n) && nwr_reg >= skip;
   endsequence
   a_oe_write_high : assert property (
      !pins.we_n && !pins.ce_n |-> pins.oe_n) else $error("oe low while writing");
   a_sector_fixed : assert property (
      data_load |-> pins.addr[15:7] == sec_reg) else $error("sector bits moved");
   a_load_count : assert property (
      done && skip != 8'h_00 |-> nwr_reg == skip + 8'h_80) else $error("wrong load count");
   a_load_window : assert property (
      $fell(pins.we_n) && nwr_reg != 8'h_00 |-> gap_reg < BLC_CYC) else $error("load gap long");
   a_write_pulse : assert property (
      $fell(pins.we_n) |=> we_held ##1 pins.we_n) else $error("write pulse malformed");
   a_poll_wait : assert property (
      $fell(pins.oe_n) |-> idle_reg >= BLC_CYC) else $error("poll before window");
   a_prot_on_done : assert property (
      $changed(prot_active) |-> done) else $error("protect moved early");
   a_prot_state : assert property (
      done && !err && skip != 8'h_00 |-> prot_active == (skip == 8'h_03))
      else $error("protect state wrong");
endmodule

bind sector_program_protect sector_program_protect_asserts #(
   .BLC_CYC  (BLC_CYC),
   .PROG_CYC (PROG_CYC)
) u_sector_program_protect_asserts (
   .clk         (clk),
   .sys_rst     (sys_rst),
   .start       (start),
   .start_req   (start_req),
   .busy        (busy),
   .done        (done),
   .err         (err),
   .prot_active (prot_active),
   .pins        (pins)
);

// ### flash_model.sv
// behavioural sector flash answering on its strobes and data lines
// assumes host pins as flash_pins_s; times in ns, no clock of its own
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_model
   import flash_host_pkg::*;
#(
   parameter int WIN_NS = 2000
) (
   // host pins
   input flash_host_pkg::flash_pins_s pins,
   // data lines to host
   output logic [7:0]                 data_lines
);
   localparam logic [71:0] EN_SEQ = {`CMD_ADDR_A, `CMD_DATA_1, `CMD_ADDR_B, `CMD_DATA_2,
                                     `CMD_ADDR_A, `CMD_DATA_EN};
   localparam logic [71:0] DIS_HI = {`CMD_ADDR_A, `CMD_DATA_1, `CMD_ADDR_B, `CMD_DATA_2,
                                     `CMD_ADDR_A, `CMD_DATA_ERS};
   // identification pair, values arbitrary
   localparam logic [15:0] HW_ID = 16'h_3CA7;
   localparam logic [15:0] SW_ID = HW_ID;
   logic [7:0]   mem [int];
   logic [7:0]   ldata [128];
   logic [127:0] lmask = '0;
   logic [143:0] hist = '0;
   logic [15:0]  a_lat, last_cnt = '0;
   logic [7:0]   last_data = '0, held = '0;
   logic [8:0]   sector;
   logic [1:0]   pend = '0;
   logic         prog_busy = 0, tog = 0, prot = 0, hang = 0;
   int           nload = 0, prog_ns = 1000;
   realtime      t_load = 0;
   wire          wr_n = pins.we_n | pins.ce_n;
   wire          rd_n = pins.ce_n | pins.oe_n;
   function automatic logic [7:0] rd_byte(input logic [15:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'h_00;
   endfunction
   // one code pair for both entry methods
   function automatic logic [7:0] id_byte(input bit hw_entry, input logic id_select_bit);
      logic [15:0] codes;
      codes = hw_entry ? HW_ID : SW_ID;
      return id_select_bit ? codes[7:0] : codes[15:8];
   endfunction
   always @(negedge wr_n) begin
      a_lat = pins.addr;
      t_load = $realtime;
   end
   always @(posedge wr_n) begin
      if (pins.doe === 1'b1 && !prog_busy) begin
         hist = {hist[119:0], a_lat, pins.dout};
         if (nload == 0) begin
            sector = a_lat[15:7];
         end
         ldata[a_lat[6:0]] = pins.dout;
         lmask[a_lat[6:0]] = 1'b1;
         last_data = pins.dout;
         nload++;
         if (hist[71:0] == EN_SEQ || hist == {DIS_HI, EN_SEQ[71:8], `CMD_DATA_DIS}) begin
            pend = (hist[7:0] == `CMD_DATA_EN) ? 2'h1 : 2'h2;
            nload = 0;
            lmask = '0;
         end
      end
   end
   always begin
      #10;
      if (nload != 0 && wr_n === 1'b1 && $realtime - t_load > WIN_NS) begin
         prog_busy = 1;
         last_cnt = 16'(nload);
         #(prog_ns);
         wait (!hang);
         for (int i = 0; i < 128; i++) begin
            mem[int'({sector, i[6:0]})] = lmask[i] ? ldata[i] : `ERASED_BYTE;
         end
         if (pend != 2'h0) begin
            prot = (pend == 2'h1);
         end
         pend = 0;
         nload = 0;
         lmask = '0;
         prog_busy = 0;
      end
   end
   always @(negedge rd_n) begin
      if (prog_busy) begin
         tog = ~tog;
      end
   end
   always @* begin
      if (rd_n === 1'b0) begin
         data_lines = prog_busy ? {~last_data[7], tog, last_data[5:0]} : rd_byte(pins.addr);
      end else begin
         data_lines = ~held;
      end
   end
   always @(data_lines) begin
      if (rd_n === 1'b0) begin
         held = data_lines;
      end
   end
endmodule

// ### testbench.sv
// self-checking bench for the sector program host
// assumes flash_model on the pins and shortened window and poll counts
`timescale 1ns/1ps
module testbench;
   import flash_host_pkg::*;
   logic        clk, sys_rst, buf_wr, start, busy, done, err, prot_active;
   logic [6:0]  buf_addr;
   logic [7:0]  buf_data, data_lines_in;
   start_req_s  start_req;
   flash_pins_s pins;
   int          err_total, compares;
   sector_program_protect #(.BLC_CYC(250), .PROG_CYC(2000)) u_sector_program_protect (
      .clk(clk), .sys_rst(sys_rst), .buf_wr(buf_wr), .buf_addr(buf_addr),
      .buf_data(buf_data), .start(start), .start_req(start_req), .busy(busy),
      .done(done), .err(err), .prot_active(prot_active), .pins(pins),
      .data_lines_in(data_lines_in));
   flash_model u_flash_model (.pins(pins), .data_lines(data_lines_in));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stage(input logic [6:0] a, input logic [7:0] d);
      buf_wr = 1;
      buf_addr = a;
      buf_data = d;
      @(negedge clk);
   endtask
   task automatic run_job(input prog_mode_e m, input logic [8:0] s, input bit poke);
      int n;
      buf_wr = 0;
      start_req = '{mode: m, sector: s};
      start = 1;
      @(negedge clk);
      start = 0;
      check(busy, 1);
      if (poke) begin
         repeat (30) @(negedge clk);
         start_req.mode = MODE_PROT_ENABLE;
         start = 1;
         @(negedge clk);
         start = 0;
      end
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      check(done, 1);
      @(negedge clk);
      check(busy, 0);
   endtask
   task automatic model_idle;
      for (int i = 0; i < 3000 && (u_flash_model.prog_busy || u_flash_model.nload != 0); i++) begin
         @(negedge clk);
      end
      check(u_flash_model.prog_busy, 0);
   endtask
   task automatic complete_run;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_program;
      stage(7'h_00, 8'h_3C);
      stage(7'h_05, 8'h_A5);
      stage(7'h_7F, 8'h_81);
      run_job(MODE_PROGRAM, 9'h_0A3, 1);
      check(prot_active, 0);
      check(u_flash_model.rd_byte(16'h_5180), 8'h_3C);
      check(u_flash_model.rd_byte(16'h_5185), 8'h_A5);
      check(u_flash_model.rd_byte(16'h_51FF), 8'h_81);
      check(u_flash_model.rd_byte(16'h_5181), 8'h_FF);
      check(u_flash_model.id_byte(1'b1, 1'b1), u_flash_model.id_byte(1'b0, 1'b1));
   endtask
   task automatic s_enable;
      stage(7'h_09, 8'h_5A);
      run_job(MODE_PROT_ENABLE, 9'h_011, 0);
      check({err, prot_active, u_flash_model.prot}, 3'h3);
      check(u_flash_model.last_cnt, 16'h_0080);
      check(u_flash_model.rd_byte(16'h_0889), 8'h_5A);
      check(u_flash_model.rd_byte(16'h_088A), 8'h_FF);
   endtask
   task automatic s_timeout;
      u_flash_model.hang = 1;
      stage(7'h_10, 8'h_77);
      run_job(MODE_PROGRAM, 9'h_002, 0);
      check({err, prot_active}, 2'h3);
      u_flash_model.hang = 0;
      model_idle();
      check(u_flash_model.rd_byte(16'h_0110), 8'h_77);
   endtask
   task automatic s_disable;
      u_flash_model.prog_ns = 5000;
      run_job(MODE_PROT_DISABLE, 9'h_1FF, 0);
      check({err, prot_active, u_flash_model.prot}, 3'h0);
      check(u_flash_model.last_cnt, 16'h_0080);
      check(u_flash_model.rd_byte(16'h_FF80), 8'h_FF);
   endtask
   task automatic s_reset_mid;
      for (int i = 0; i < 8; i++) begin
         stage(i[6:0], 8'h_40 + i[7:0]);
      end
      buf_wr = 0;
      start_req = '{mode: MODE_PROGRAM, sector: 9'h_003};
      start = 1;
      @(negedge clk);
      start = 0;
      repeat (60) @(negedge clk);
      sys_rst = 1;
      repeat (2) @(negedge clk);
      sys_rst = 0;
      check({busy, done, pins.doe, pins.ce_n, pins.oe_n, pins.we_n}, 6'h07);
      model_idle();
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      sys_rst = 1;
      buf_wr = 0;
      buf_addr = 7'h_00;
      buf_data = 8'h_00;
      start = 0;
      start_req = '{mode: MODE_PROGRAM, sector: 9'h_000};
      err_total = 0;
      compares = 0;
      repeat (3) @(negedge clk);
      sys_rst = 0;
      s_program();
      s_enable();
      s_timeout();
      s_disable();
      s_reset_mid();
      complete_run();
   end
   initial begin
      #500_000;
      err_total++;
      complete_run();
   end
endmodule
